// file: test/flash_front_props.sv
// Port-level assertion checker for the flash command front end
`timescale 1ns/1ns
module flash_front_props #(
   parameter int unsigned WRITE_CYCLES = flash_pkg::STAT_WRITE_CYCLES
) (
   input wire logic                 ref_clk,
   input wire logic                 rstn,
   input wire flash_pkg::spi_pins_s pins_in,
   input wire logic [3:0]           io_out,
   input wire logic [3:0]           io_oe_n,
   input wire logic [23:0]          mem_addr,
   input wire logic [7:0]           mem_rdata,
   input wire logic [7:0]           status_low,
   input wire logic [7:0]           status_high
);
   import flash_pkg::*;
   logic [31:0] busy_cnt_q;
   logic [31:0] busy_cnt_d;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   // Counts sampled busy cycles so the timed write length can be checked exactly
   assign busy_cnt_d = status_low[BUSY_POS] ? busy_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         busy_cnt_q <= 32'h0;
      else
         busy_cnt_q <= busy_cnt_d;
   end

   ro_high_a: assert property (status_high[7:2] == 6'h00)
      else $error("status_high read-only bits changed");
   busy_gate_a: assert property ($rose(status_low[BUSY_POS]) |-> status_low[WLATCH_POS])
      else $error("write cycle started without latch");
   busy_end_a: assert property ($fell(status_low[BUSY_POS]) |-> !status_low[WLATCH_POS])
      else $error("latch not cleared at end of write cycle");
   busy_len_a: assert property ($fell(status_low[BUSY_POS]) |-> busy_cnt_q == WRITE_CYCLES)
      else $error("write cycle length wrong");
   stat_hold_a: assert property (($changed(status_high) || $changed(status_low[7:2]))
      |-> status_low[BUSY_POS] || $past(status_low[BUSY_POS]))
      else $error("status bits changed outside a write cycle");
   oe_idle_a: assert property (pins_in.cs_n [*8] |-> ##2 io_oe_n == 4'hf)
      else $error("output driven while deselected");
   quad_oe_a: assert property (!io_oe_n[3] |-> status_high[QUAD_EN_POS])
      else $error("quad lanes driven with quad enable clear");
   busy_noread_a: assert property (!io_oe_n[0] |-> !status_low[BUSY_POS])
      else $error("data read driven while busy");
   oe_shape_a: assert property (io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
      else $error("illegal output enable pattern");
endmodule

bind flash_front flash_front_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
   .ref_clk(ref_clk), .rstn(rstn), .pins_in(pins_in), .io_out(io_out), .io_oe_n(io_oe_n),
   .mem_addr(mem_addr), .mem_rdata(mem_rdata), .status_low(status_low),
   .status_high(status_high));

// file: test/flash_front_tb_top.sv
// Self-checking bench for the flash command front end with a reference model
`timescale 1ns/1ns
module flash_front_tb_top;
   import flash_pkg::*;
   localparam int WCYC = 1500;
   logic        ref_clk   = 1'b0;
   logic        rstn      = 1'b0;
   logic [7:0]  mem_rdata = 8'h00;
   spi_pins_s   pins_in;
   logic [3:0]  io_out;
   logic [3:0]  io_oe_n;
   logic [23:0] mem_addr;
   logic [7:0]  status_low;
   logic [7:0]  status_high;
   logic [15:0] rx;
   logic        drv;
   int          error_cnt   = 0;
   int          check_count = 0;
   int          cyc         = 0;
   int          seed        = 32'h6913;
   int          sl          = 0;
   int          sh          = 0;
   logic [7:0]  rops [4]    = '{OP_READ, OP_FAST_READ, OP_DUAL_READ, OP_QUAD_READ};
   int          rdum [4]    = '{0, 8, 8, 8};
   int          rlane [4]   = '{1, 1, 2, 4};

   flash_front #(.WRITE_CYCLES(WCYC)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .pins_in(pins_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
      .status_low(status_low), .status_high(status_high));
   spi_host_model u_host (.ref_clk(ref_clk), .io_out(io_out), .io_oe_n(io_oe_n), .pins(pins_in));

   initial forever #5 ref_clk = ~ref_clk;

   function automatic logic [7:0] mem_fn(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
   endfunction

   always @(negedge ref_clk) mem_rdata <= mem_fn(mem_addr);

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Frames run far shorter than this ceiling; reaching it means a hang
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      u_host.frame(op, 24'h0, 0, 0, 0, 1, rx, drv);
      sl = (op == OP_WRITE_ENABLE) ? (sl | 2) : (sl & 8'hfd);
      check("status regs", {status_high, status_low}, {sh[7:0], sl[7:0]});
   endtask

   task automatic stat_chk(input logic [7:0] op, input logic [7:0] exp);
      u_host.frame(op, 24'h0, 0, 0, 16, 1, rx, drv);
      check("status read", rx, {exp, exp});
   endtask

   task automatic wsr(input int n, input logic [15:0] d);
      logic ok;
      ok = sl[1] && (n == 8 || n == 16);
      u_host.frame(OP_WRITE_STAT, {8'h0, d}, n, 0, 0, 1, rx, drv);
      if (ok)
      begin
         sl = (n == 16 ? d[15:8] : d[7:0]) & LOW_WR_MASK;
         sh = (n == 16) ? (d[7:0] & HIGH_WR_MASK) : 0;
         u_host.frame(OP_READ_STAT_LOW, 24'h0, 0, 0, 16, 1, rx, drv);
         check("busy poll", {12'h0, rx[9:8], rx[1:0]}, 16'hf);
         u_host.frame(OP_READ, 24'h10, 24, 0, 16, 1, rx, drv);
         check("busy read drive", {15'h0, drv}, 16'h0);
         repeat (500) @(negedge ref_clk);
      end
      check("status regs", {status_high, status_low}, {sh[7:0], sl[7:0]});
   endtask

   initial
   begin
      logic [23:0] a;
      repeat (4) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (12) @(negedge ref_clk);
      check("status regs", {status_high, status_low}, 16'h0);
      stat_chk(OP_READ_STAT_LOW, 8'h00);
      $display("test reset done");
      cmd(OP_WRITE_ENABLE);
      stat_chk(OP_READ_STAT_LOW, 8'h02);
      cmd(OP_WRITE_DISABLE);
      wsr(8, 16'h00ff);
      $display("test latch done");
      cmd(OP_WRITE_ENABLE);
      wsr(16, 16'hffff);
      stat_chk(OP_READ_STAT_LOW, sl[7:0]);
      stat_chk(OP_READ_STAT_HIGH, sh[7:0]);
      $display("test status write done");
      for (int k = 0; k < 4; k++)
      begin
         a = 24'($random(seed));
         u_host.frame(rops[k], a, 24, rdum[k], 16 / rlane[k], rlane[k], rx, drv);
         check("read data", rx, {mem_fn(a), mem_fn(a + 24'h1)});
      end
      $display("test reads done");
      cmd(OP_WRITE_ENABLE);
      wsr(12, 16'h0abc);
      wsr(8, 16'h005f);
      u_host.frame(OP_QUAD_READ, 24'h40, 24, 8, 4, 4, rx, drv);
      check("quad refused drive", {15'h0, drv}, 16'h0);
      $display("test partial write done");
      report_and_stop();
   end
endmodule

// file: test/spi_host_model.sv
// Behavioural SPI mode 0 host that frames commands toward the flash front end
`timescale 1ns/1ns
module spi_host_model (
   input  wire logic            ref_clk,
   input  wire logic [3:0]      io_out,
   input  wire logic [3:0]      io_oe_n,
   output flash_pkg::spi_pins_s pins
);
   import flash_pkg::*;
   logic       cs_n_q   = 1'b1;
   logic       sclk_q   = 1'b0;
   logic [3:0] host_oe  = 4'h1;
   logic [3:0] host_val = 4'h0;
   logic [3:0] tog      = 4'h5;
   logic       drv_seen = 1'b0;
   logic [3:0] line;
   logic [3:0] smp;

   // Undriven lines toggle so a stale level never passes for data
   always @(negedge ref_clk) tog <= ~tog;
   always @(posedge ref_clk) if (io_oe_n != 4'hf) drv_seen <= 1'b1;
   assign line = (~io_oe_n & io_out) | (io_oe_n & host_oe & host_val) | (io_oe_n & ~host_oe & tog);
   assign smp  = line;
   assign pins = '{cs_n: cs_n_q, sclk: sclk_q, io: line};

   task automatic half();
      repeat (8) @(negedge ref_clk);
   endtask

   task automatic frame(
      input  logic [7:0]  op,
      input  logic [23:0] tx,
      input  int          ntx,
      input  int          ndum,
      input  int          nrx,
      input  int          lanes,
      output logic [15:0] rx,
      output logic        drv
   );
      int n;
      rx = 16'h0;
      // dummy clocks between address and data
      n = 8 + ntx + ndum + nrx;
      @(negedge ref_clk);
      drv_seen = 1'b0;
      cs_n_q = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         host_val[0] = (i < 8) ? op[7 - i] : (i < 8 + ntx) ? tx[ntx - 1 - (i - 8)] : 1'b0;
         // wide reads release every lane before data
         if (i >= 8 + ntx && lanes > 1)
            host_oe = 4'h0;
         half();
         sclk_q = 1'b1;
         if (i >= n - nrx)
            rx = (rx << lanes) | ((lanes == 1) ? {15'h0, smp[1]} : {12'h0, smp & (lanes == 2 ? 4'h3 : 4'hf)});
         half();
         sclk_q = 1'b0;
      end
      half();
      cs_n_q = 1'b1;
      host_oe = 4'h1;
      repeat (16) @(negedge ref_clk);
      drv = drv_seen;
   endtask
endmodule

// file: verilog/flash_front.sv
// Serial flash command front end: latch, status registers and output reads
// Notes on behaviour
// - Write-enable opcode sets the write latch
// - Status write refused while latch is clear
// - Frame by chip select, sample rising edge
// - Write-disable opcode clears the write latch
// - Latch cleared at power-up and write completion
// - Status read shifts register out MSB first
// - Status reads accepted even while busy
// - Status read repeats fresh until deselect
// - Status write: opcode, one or two bytes
// - Only protect, range and quad bits writable
// - Wrong data bit count discards status write
// - One-byte write clears quad and protect2
// - Timed write cycle with busy, then clear
// - Status bits default to zero
// - Read: opcode, 24-bit address, data out
// - Address increments after every output byte
// - Reads ignored while busy is set
// - Fast read adds eight dummy clocks
// - Dual read: dummy clocks, two bits/clock
// - Quad read only when quad enable set
// - Dual lanes: IO1 odd bits, IO0 even
// - Quad lanes: high nibble first on IO3..0
`timescale 1ns/1ns
module flash_front #(
   parameter int unsigned WRITE_CYCLES = flash_pkg::STAT_WRITE_CYCLES
) (
   input  wire logic                ref_clk,
   input  wire logic                rstn,
   input  wire flash_pkg::spi_pins_s pins_in,
   output logic      [3:0]          io_out,
   output logic      [3:0]          io_oe_n,
   output logic      [23:0]         mem_addr,
   input  wire logic [7:0]          mem_rdata,
   output logic      [7:0]          status_low,
   output logic      [7:0]          status_high
);
   import flash_pkg::*;

   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

   function automatic logic [2:0] lane_step(input lane_e lane);
      case (lane)
         LANE_DUAL: lane_step = 3'd2;
         LANE_QUAD: lane_step = 3'd4;
         default:   lane_step = 3'd1;
      endcase
   endfunction

   // Number of falling edges that carry one byte, minus one
   function automatic logic [2:0] lane_last(input lane_e lane);
      case (lane)
         LANE_DUAL: lane_last = 3'd3;
         LANE_QUAD: lane_last = 3'd1;
         default:   lane_last = 3'd7;
      endcase
   endfunction

   logic             rst_meta_q;
   logic             rst_n_q;
   logic [5:0]       pin_w;
   spi_pins_s        pin;
   logic             sclk_prev_q;
   logic             cs_prev_q;
   phase_e           phase_q;
   phase_e           phase_d;
   phase_e           opc_phase_w;
   logic [5:0]       cnt_q;
   logic [23:0]      in_sh_q;
   logic [7:0]       op_w;
   lane_e            lane_q;
   lane_e            opc_lane_w;
   logic             stat_mode_q;
   logic             stat_high_q;
   logic             dummy_q;
   logic [23:0]      addr_q;
   logic [2:0]       slot_q;
   logic [7:0]       out_sh_q;
   logic [5:0]       prot_low_q;
   logic [1:0]       prot_high_q;
   logic             wlatch_q;
   logic             busy_q;
   logic [CNT_W-1:0] busy_cnt_q;
   logic             rise_w;
   logic             fall_w;
   logic             frame_end_w;
   logic             frame_start_w;
   logic             last_opc_w;
   logic             last_addr_w;
   logic             phase_done_w;
   logic             load_w;
   logic [7:0]       src_w;
   logic [3:0]       drive_w;
   logic [3:0]       oe_n_w;
   logic [7:0]       sel_status_w;
   logic             wstat_one_w;
   logic             wstat_two_w;
   logic             write_done_w;
   logic             set_latch_w;
   logic             clr_latch_w;

   // Reset is released through two flops so all logic leaves reset together
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   pin_filter #(
      .W       (6),
      .RST_VAL (PIN_IDLE)
   ) u_pin_filter (
      .ref_clk (ref_clk),
      .rst_n   (rst_n_q),
      .d       (pins_in),
      .q       (pin_w)
   );

   assign pin = spi_pins_s'(pin_w);

   assign rise_w        = pin.sclk & ~sclk_prev_q & ~pin.cs_n;
   assign fall_w        = ~pin.sclk & sclk_prev_q & ~pin.cs_n;
   assign frame_start_w = ~pin.cs_n & cs_prev_q;
   assign frame_end_w   = pin.cs_n & ~cs_prev_q;

   assign status_low  = {prot_low_q, wlatch_q, busy_q};
   assign status_high = {6'h00, prot_high_q};
   assign sel_status_w = stat_high_q ? status_high : status_low;

   assign op_w        = {in_sh_q[6:0], pin.io[0]};
   assign last_opc_w  = rise_w && (phase_q == PH_OPCODE) && (cnt_q == OPC_LAST);
   assign last_addr_w = rise_w && (phase_q == PH_ADDR) && (cnt_q == ADDR_LAST);
   assign phase_done_w = last_opc_w || last_addr_w ||
                         (rise_w && (phase_q == PH_DUMMY) && (cnt_q == DUMMY_LAST));

   // Opcode decode: only status reads pass while the write cycle runs
   always_comb
   begin
      opc_phase_w = PH_IGNORE;
      opc_lane_w  = LANE_SINGLE;
      case (op_w)
         OP_READ_STAT_LOW,
         OP_READ_STAT_HIGH: opc_phase_w = PH_STREAM;
         OP_WRITE_STAT:     opc_phase_w = (wlatch_q && !busy_q) ? PH_WSTAT : PH_IGNORE;
         OP_READ,
         OP_FAST_READ:      opc_phase_w = busy_q ? PH_IGNORE : PH_ADDR;
         OP_DUAL_READ:
         begin
            opc_phase_w = busy_q ? PH_IGNORE : PH_ADDR;
            opc_lane_w  = LANE_DUAL;
         end
         OP_QUAD_READ:
         begin
            opc_phase_w = (busy_q || !prot_high_q[QUAD_EN_POS - PROTECT2_POS]) ?
                          PH_IGNORE : PH_ADDR;
            opc_lane_w  = LANE_QUAD;
         end
         default:           opc_phase_w = PH_IGNORE;
      endcase
   end

   always_comb
   begin
      phase_d = phase_q;
      case (phase_q)
         PH_OPCODE: phase_d = last_opc_w ? opc_phase_w : PH_OPCODE;
         PH_ADDR:   phase_d = last_addr_w ? (dummy_q ? PH_DUMMY : PH_STREAM) : PH_ADDR;
         PH_DUMMY:  phase_d = phase_done_w ? PH_STREAM : PH_DUMMY;
         default:   phase_d = phase_q;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= pin.sclk;
         cs_prev_q   <= pin.cs_n;
      end
   end

   // Frame sequencing; chip select high always returns to opcode phase
   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         phase_q <= PH_OPCODE;
         cnt_q   <= 6'h00;
         in_sh_q <= 24'h000000;
      end
      else if (frame_start_w || frame_end_w)
      begin
         phase_q <= PH_OPCODE;
         cnt_q   <= 6'h00;
      end
      else if (rise_w)
      begin
         phase_q <= phase_d;
         in_sh_q <= {in_sh_q[22:0], pin.io[0]};
         cnt_q   <= phase_done_w ? 6'h00 : ((cnt_q == CNT_SAT) ? CNT_SAT : cnt_q + 6'h01);
      end
   end

   // Command attributes captured with the last opcode bit
   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         lane_q      <= LANE_SINGLE;
         stat_mode_q <= 1'b0;
         stat_high_q <= 1'b0;
         dummy_q     <= 1'b0;
      end
      else if (last_opc_w)
      begin
         lane_q      <= opc_lane_w;
         stat_mode_q <= (op_w == OP_READ_STAT_LOW) || (op_w == OP_READ_STAT_HIGH);
         stat_high_q <= (op_w == OP_READ_STAT_HIGH);
         dummy_q     <= (op_w != OP_READ);
      end
   end

   // Output path: a new byte is loaded at the first falling edge of each byte
   assign load_w = (slot_q == 3'd0);
   assign src_w  = load_w ? (stat_mode_q ? sel_status_w : mem_rdata) : out_sh_q;

   always_comb
   begin
      drive_w = 4'h0;
      oe_n_w  = 4'hf;
      case (lane_q)
         LANE_DUAL:
         begin
            drive_w = {2'b00, src_w[7], src_w[6]};
            oe_n_w  = 4'hc;
         end
         LANE_QUAD:
         begin
            drive_w = src_w[7:4];
            oe_n_w  = 4'h0;
         end
         default:
         begin
            drive_w = {2'b00, src_w[7], 1'b0};
            oe_n_w  = 4'hd;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         io_out   <= 4'h0;
         io_oe_n  <= 4'hf;
         out_sh_q <= 8'h00;
         slot_q   <= 3'd0;
      end
      else if (frame_end_w || phase_q != PH_STREAM)
      begin
         io_oe_n <= 4'hf;
         slot_q  <= 3'd0;
      end
      else if (fall_w)
      begin
         io_out   <= drive_w;
         io_oe_n  <= oe_n_w;
         out_sh_q <= src_w << lane_step(lane_q);
         slot_q   <= (slot_q == lane_last(lane_q)) ? 3'd0 : slot_q + 3'd1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         addr_q <= 24'h000000;
      else if (last_addr_w)
         addr_q <= {in_sh_q[22:0], pin.io[0]};
      else if (fall_w && phase_q == PH_STREAM && load_w && !stat_mode_q)
         addr_q <= addr_q + 24'h000001;
   end

   assign mem_addr = addr_q;

   assign wstat_one_w  = frame_end_w && (phase_q == PH_WSTAT) && (cnt_q == WSTAT_ONE_BYTE);
   assign wstat_two_w  = frame_end_w && (phase_q == PH_WSTAT) && (cnt_q == WSTAT_TWO_BYTES);
   assign write_done_w = busy_q && (busy_cnt_q == '0);
   assign set_latch_w  = last_opc_w && !busy_q && (op_w == OP_WRITE_ENABLE);
   assign clr_latch_w  = last_opc_w && !busy_q && (op_w == OP_WRITE_DISABLE);

   // Writable status bits; everything resets to zero
   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         prot_low_q  <= STATUS_RESET[7:2];
         prot_high_q <= STATUS_RESET[1:0];
      end
      else if (wstat_one_w)
      begin
         prot_low_q  <= in_sh_q[7:2] & LOW_WR_MASK[7:2];
         prot_high_q <= 2'b00;
      end
      else if (wstat_two_w)
      begin
         prot_low_q  <= in_sh_q[15:10] & LOW_WR_MASK[7:2];
         prot_high_q <= in_sh_q[1:0] & HIGH_WR_MASK[1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         busy_q     <= 1'b0;
         busy_cnt_q <= '0;
      end
      else if (wstat_one_w || wstat_two_w)
      begin
         busy_q     <= 1'b1;
         busy_cnt_q <= CNT_W'(WRITE_CYCLES - 1);
      end
      else if (write_done_w)
         busy_q <= 1'b0;
      else if (busy_q)
         busy_cnt_q <= busy_cnt_q - CNT_W'(1);
   end

   // latch cleared on completion
   // Set and completion never meet: enable is ignored while busy
   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         wlatch_q <= STATUS_RESET[WLATCH_POS];
      else if (set_latch_w)
         wlatch_q <= 1'b1;
      else if (clr_latch_w || write_done_w)
         wlatch_q <= 1'b0;
   end
endmodule

// file: verilog/flash_pkg.sv
// Constants, opcodes and types shared by the serial flash command front end
package flash_pkg;

   // Opcodes taken from the serial input, most significant bit first
   localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
   localparam logic [7:0] OP_READ_STAT_LOW   = 8'h05;
   localparam logic [7:0] OP_READ_STAT_HIGH  = 8'h35;
   localparam logic [7:0] OP_WRITE_STAT      = 8'h01;
   localparam logic [7:0] OP_READ            = 8'h03;
   localparam logic [7:0] OP_FAST_READ       = 8'h0b;
   localparam logic [7:0] OP_DUAL_READ       = 8'h3b;
   localparam logic [7:0] OP_QUAD_READ       = 8'h6b;

   // Status register layout
   localparam int         BUSY_POS           = 0;
   localparam int         WLATCH_POS         = 1;
   localparam int         PROTECT2_POS       = 0;
   localparam int         QUAD_EN_POS        = 1;
   localparam logic [7:0] LOW_WR_MASK        = 8'hfc;
   localparam logic [7:0] HIGH_WR_MASK       = 8'h03;
   localparam logic [7:0] STATUS_RESET       = 8'h00;

   // Frame lengths in serial clocks
   localparam logic [5:0] OPC_LAST           = 6'h07;
   localparam logic [5:0] ADDR_LAST          = 6'h17;
   localparam logic [5:0] DUMMY_LAST         = 6'h07;
   localparam logic [5:0] WSTAT_ONE_BYTE     = 6'h08;
   localparam logic [5:0] WSTAT_TWO_BYTES    = 6'h10;
   localparam logic [5:0] CNT_SAT            = 6'h3f;
   localparam int         ADDR_BITS          = 24;

   // Self-timed status write cycle
   localparam int         CLK_PERIOD_NS      = 10;
   localparam int         STAT_WRITE_TIME_US = 15;
   localparam int         STAT_WRITE_CYCLES  = STAT_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      PH_OPCODE,
      PH_ADDR,
      PH_DUMMY,
      PH_STREAM,
      PH_WSTAT,
      PH_IGNORE
   } phase_e;

   typedef enum logic [1:0] {
      LANE_SINGLE,
      LANE_DUAL,
      LANE_QUAD
   } lane_e;

   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic [3:0] io;
   } spi_pins_s;

   // Chip select high, clock low, data lines low
   localparam spi_pins_s PIN_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

endpackage

// file: verilog/pin_filter.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_filter #(
   parameter int             W       = 6,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree_w;

   // A bit moves only once the last two stages agree
   assign agree_w = ~(s2_q ^ s3_q);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RST_VAL;
         s2_q   <= RST_VAL;
         s3_q   <= RST_VAL;
         q      <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         s2_q   <= meta_q;
         s3_q   <= s2_q;
         q      <= (agree_w & s3_q) | (~agree_w & q);
      end
   end
endmodule
